// >>> core/rsc_ramp_tail.sv
// File: ramp successor control, post-ramp calibration and readback registers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [RULE1] After second segment: successor bit 0 picks first segment, 1 repeats
// [RULE2] Second segment advance: 0 length timeout, 1 trigger A, 2 trigger B
// [RULE3] Post-ramp recalibrate bit starts an oscillator calibration at ramp end
// [RULE4] Wait count scaled by two to the wait exponent; exponent resets to 7
// [RULE5] Tune lock state read back as two-bit code
// [RULE6] Selected oscillator core read back in three bits, 0 invalid
// [RULE7] Capacitor code read back in eight bits, reset 183
// [RULE8] Amplitude code read back in nine bits, reset 170
// [RULE9] Successor bit and advance source reset to 0
// [RULE10] Trigger A derived from four-bit select of pin edges or always
// [RULE11] Wait the longer of scaled count and actual calibration time
// [RULE12] Active segment switches the cycle after the advance event
module rsc_ramp_tail
  import rsc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [15:0]      rdata,
  input  wire logic        ramp_clock_pin,
  input  wire logic        direction_pin,
  input  wire logic        trigger_b,
  input  wire logic        ramp_run,
  input  wire logic        cal_done,
  input  wire logic        cal_valid,
  input  wire rsc_cal_s    cal_result,
  output logic             active_segment,
  output logic             cal_start,
  output logic             ramp_hold
);
  typedef enum logic [2:0] {
    RSC_ST_RAMP = 3'b001,
    RSC_ST_CAL  = 3'b010,
    RSC_ST_WAIT = 3'b100
  } rsc_state_e;

  rsc_state_e  state;
  rsc_state_e  next_state;
  logic        second_segment_successor;
  logic [1:0]  second_segment_advance_source;
  logic [9:0]  calibration_wait_count;
  logic        post_ramp_recalibrate;
  logic [2:0]  wait_exponent;
  logic [15:0] first_segment_length;
  logic [15:0] second_segment_length;
  logic [3:0]  trigger_a_select;
  rsc_cal_s    cal_q;
  logic [15:0] seg_cnt;
  logic [2:0]  clk_sync;
  logic [2:0]  dir_sync;
  logic        clk_lvl;
  logic        dir_lvl;
  logic        cal_seen;
  logic        wait_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire wr_succ = wr_en && (addr == RSC_ADDR_SUCC);
  wire wr_cal  = wr_en && (addr == RSC_ADDR_CAL);
  wire wr_len0 = wr_en && (addr == RSC_ADDR_LEN0);
  wire wr_len1 = wr_en && (addr == RSC_ADDR_LEN1);
  wire wr_trga = wr_en && (addr == RSC_ADDR_TRGA);

  // Register writes; reset values set the documented defaults
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      second_segment_successor      <= 1'b0;                // RULE9
      second_segment_advance_source <= RSC_SRC_LEN;         // RULE9
      calibration_wait_count        <= 10'h000;
      post_ramp_recalibrate         <= 1'b0;
      wait_exponent                 <= RSC_SCALE_RST;       // RULE4
      first_segment_length          <= RSC_LEN_RST;
      second_segment_length         <= RSC_LEN_RST;
      trigger_a_select              <= RSC_TA_OFF;
    end else begin
      if (wr_succ) begin
        second_segment_successor      <= wdata[RSC_SUCC_BIT];
        second_segment_advance_source <= wdata[RSC_SRC_LSB +: 2];
        calibration_wait_count        <= wdata[RSC_DLY_LSB +: 10];
      end
      if (wr_cal) begin
        post_ramp_recalibrate <= wdata[RSC_RECAL_BIT];
        wait_exponent         <= wdata[RSC_SCALE_LSB +: 3];
      end
      if (wr_len0) first_segment_length  <= wdata;
      if (wr_len1) second_segment_length <= wdata;
      if (wr_trga) trigger_a_select <= wdata[RSC_TRGA_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration results captured while cal_valid is high; reset shows documented codes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cal_q <= '{lock: 2'h0, core: 3'h0, cap: RSC_CAP_RST, amp: RSC_AMP_RST};
    end else if (cal_valid) begin
      cal_q <= cal_result;                                  // RULE5
    end
  end

  // Readback mux; unmapped addresses read zero
  wire [15:0] rd_mux =
    (addr == RSC_ADDR_SUCC) ? {calibration_wait_count, 1'b0,
                               second_segment_successor, 2'h0,
                               second_segment_advance_source} :
    (addr == RSC_ADDR_CAL)  ? {11'h000, post_ramp_recalibrate, 1'b0,
                               wait_exponent} :
    (addr == RSC_ADDR_LOCK) ? {5'h00, cal_q.lock, 1'b0,
                               cal_q.core, 5'h00} :         // RULE5 RULE6
    (addr == RSC_ADDR_CAP)  ? {8'h00, cal_q.cap} :          // RULE7
    (addr == RSC_ADDR_AMP)  ? {7'h00, cal_q.amp} :          // RULE8
    (addr == RSC_ADDR_LEN0) ? first_segment_length :
    (addr == RSC_ADDR_LEN1) ? second_segment_length :
    (addr == RSC_ADDR_TRGA) ? {9'h000, trigger_a_select, 3'h0} :
    (addr == RSC_ADDR_STAT) ? {13'h0000, state == RSC_ST_WAIT,
                               state == RSC_ST_CAL, active_segment} :
    16'h0000;

  always_ff @(posedge sys_clk) begin
    if (!nrst) rdata <= 16'h0000;
    else       rdata <= rd_en ? rd_mux : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      clk_sync <= 3'h0;
      dir_sync <= 3'h0;
      clk_lvl  <= 1'b0;
      dir_lvl  <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], ramp_clock_pin};
      dir_sync <= {dir_sync[1:0], direction_pin};
      if (clk_sync[1] == clk_sync[2]) clk_lvl <= clk_sync[2];
      if (dir_sync[1] == dir_sync[2]) dir_lvl <= dir_sync[2];
    end
  end

  wire clk_rise = clk_sync[1] && clk_sync[2] && !clk_lvl;
  wire clk_fall = !clk_sync[1] && !clk_sync[2] && clk_lvl;
  wire dir_rise = dir_sync[1] && dir_sync[2] && !dir_lvl;
  wire dir_fall = !dir_sync[1] && !dir_sync[2] && dir_lvl;

  // Trigger A select; reserved codes never fire
  wire trig_a =
    (trigger_a_select == RSC_TA_CLK_R) ? clk_rise :         // RULE10
    (trigger_a_select == RSC_TA_DIR_R) ? dir_rise :
    (trigger_a_select == RSC_TA_ALW)   ? 1'b1 :
    (trigger_a_select == RSC_TA_CLK_F) ? clk_fall :
    (trigger_a_select == RSC_TA_DIR_F) ? dir_fall : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Segment length timeout and advance source selection
  wire [15:0] cur_len = active_segment ? second_segment_length
                                       : first_segment_length;
  wire len_done = (seg_cnt >= cur_len);
  wire [1:0] src_sel = second_segment_advance_source;
  // First segment always times out here; its own source lives elsewhere
  wire advance = ramp_run && (state == RSC_ST_RAMP) &&
    (!active_segment ? len_done :
     (src_sel == RSC_SRC_LEN)  ? len_done :                  // RULE2
     (src_sel == RSC_SRC_TRGA) ? trig_a :
     (src_sel == RSC_SRC_TRGB) ? trigger_b : 1'b0);
  // Successor after second segment; first segment always goes to second
  wire next_seg = active_segment ? second_segment_successor : 1'b1; // RULE1
  wire ramp_end = advance && active_segment;
  wire start_cal = ramp_end && post_ramp_recalibrate;       // RULE3

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      active_segment <= 1'b0;
      seg_cnt        <= 16'h0000;
    end else if (advance) begin
      active_segment <= next_seg;                           // RULE12
      seg_cnt        <= 16'h0000;
    end else if (ramp_run && state == RSC_ST_RAMP) begin
      seg_cnt <= seg_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration state machine: hold ramp until both waits are over
  always_comb begin
    next_state = state;
    case (state)
      RSC_ST_RAMP: if (start_cal) next_state = RSC_ST_CAL;
      // Calibration may finish before or after the programmed wait
      RSC_ST_CAL: begin
        if (cal_seen && !wait_busy) next_state = RSC_ST_RAMP;  // RULE11
        else if (cal_seen)          next_state = RSC_ST_WAIT;
      end
      RSC_ST_WAIT: if (!wait_busy) next_state = RSC_ST_RAMP;  // RULE11
      default:     next_state = RSC_ST_RAMP;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state     <= RSC_ST_RAMP;
      cal_start <= 1'b0;
      ramp_hold <= 1'b0;
      cal_seen  <= 1'b0;
    end else begin
      state     <= next_state;
      cal_start <= start_cal;                               // RULE3
      ramp_hold <= (next_state != RSC_ST_RAMP);             // RULE11
      if (start_cal)     cal_seen <= 1'b0;
      else if (cal_done) cal_seen <= 1'b1;
    end
  end

  rsc_wait_timer u_wait (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .start   (start_cal),
    .count   (calibration_wait_count),
    .scale   (wait_exponent),
    .busy    (wait_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks: successor choice and advance sources
  a_succ_first: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!nrst)
    ramp_end && !second_segment_successor |=> !active_segment)
    else $error("first segment did not follow");
  a_succ_repeat: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!nrst)
    ramp_end && second_segment_successor |=> active_segment)
    else $error("second segment did not repeat");
  a_trga_adv: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!nrst)
    ramp_run && state == RSC_ST_RAMP && active_segment &&
    src_sel == RSC_SRC_TRGA && trig_a |=> seg_cnt == 16'h0000)
    else $error("trigger A did not advance");
  a_trgb_adv: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!nrst)
    ramp_run && state == RSC_ST_RAMP && active_segment &&
    src_sel == RSC_SRC_TRGB && trigger_b |=> seg_cnt == 16'h0000)
    else $error("trigger B did not advance");
  a_src_resv: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!nrst)
    active_segment && (&src_sel) |=> active_segment)
    else $error("reserved source advanced");
  a_seg_hold: assert property ( // RULE12
    @(posedge sys_clk) disable iff (!nrst)
    !advance |=> $stable(active_segment))
    else $error("segment changed without an advance");
  a_trga_off: assert property ( // RULE10
    @(posedge sys_clk) disable iff (!nrst)
    trigger_a_select == RSC_TA_OFF |-> !trig_a)
    else $error("disabled trigger A fired");

  // Checks: calibration hand-off; ramp_hold mirrors any non-ramp state
  a_recal_start: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!nrst)
    ramp_end && post_ramp_recalibrate |=> cal_start && ramp_hold)
    else $error("recalibration not started");
  a_recal_off: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!nrst)
    ramp_end && !post_ramp_recalibrate |=> !cal_start && !ramp_hold)
    else $error("recalibration without request");
  a_hold_wait: assert property ( // RULE11
    @(posedge sys_clk) disable iff (!nrst)
    state != RSC_ST_RAMP && wait_busy |=> state != RSC_ST_RAMP)
    else $error("ramp resumed before wait ended");
  a_hold_cal: assert property ( // RULE11
    @(posedge sys_clk) disable iff (!nrst)
    state == RSC_ST_CAL && !cal_seen |=> state == RSC_ST_CAL)
    else $error("ramp resumed before calibration ended");
  a_wait_state: assert property ( // RULE11
    @(posedge sys_clk) disable iff (!nrst)
    state == RSC_ST_WAIT |-> cal_seen && ramp_hold)
    else $error("wait state without finished calibration");

  // Checks: values seen right after reset
  a_scale_reset: assert property ( // RULE4
    @(posedge sys_clk)
    $rose(nrst) |-> wait_exponent == RSC_SCALE_RST)
    else $error("wait exponent reset wrong");
  a_cap_reset: assert property ( // RULE7
    @(posedge sys_clk)
    $rose(nrst) |-> cal_q.cap == RSC_CAP_RST && cal_q.amp == RSC_AMP_RST)
    else $error("readback reset wrong");
  a_succ_reset: assert property ( // RULE9
    @(posedge sys_clk)
    $rose(nrst) |-> !second_segment_successor && src_sel == RSC_SRC_LEN)
    else $error("successor reset wrong");

  // Checks: readback fields one cycle after the strobe
  a_lock_read: assert property ( // RULE5
    @(posedge sys_clk) disable iff (!nrst)
    rd_en && addr == RSC_ADDR_LOCK |=> rdata[RSC_LOCK_LSB +: 2] ==
    $past(cal_q.lock))
    else $error("lock readback wrong");
  a_core_read: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!nrst)
    rd_en && addr == RSC_ADDR_LOCK |=> rdata[RSC_CORE_LSB +: 3] ==
    $past(cal_q.core))
    else $error("core readback wrong");
  a_cap_read: assert property ( // RULE7
    @(posedge sys_clk) disable iff (!nrst)
    rd_en && addr == RSC_ADDR_CAP |=> rdata == {8'h00, $past(cal_q.cap)})
    else $error("capacitor readback wrong");
  a_amp_read: assert property ( // RULE8
    @(posedge sys_clk) disable iff (!nrst)
    rd_en && addr == RSC_ADDR_AMP |=> rdata == {7'h00, $past(cal_q.amp)})
    else $error("amplitude readback wrong");

  // Main scenarios
  c_wait:   cover property (@(posedge sys_clk) state == RSC_ST_WAIT);
  c_repeat: cover property (@(posedge sys_clk) ramp_end && next_seg);
  c_recal:  cover property (@(posedge sys_clk) start_cal);
  c_trga:   cover property (@(posedge sys_clk) trig_a && clk_rise);
  c_resume: cover property (@(posedge sys_clk)
    state == RSC_ST_CAL ##1 state == RSC_ST_RAMP);

endmodule : rsc_ramp_tail

// >>> core/rsc_wait_timer.sv
// File: calibration wait timer, programmed count scaled by a power of two
`timescale 1ns/1ps
module rsc_wait_timer
  import rsc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic [9:0] count,
  input  wire logic [2:0] scale,
  output logic            busy
);
  logic [16:0] remain;

  // Load count << scale with bit 0 forced to 1; zero count still costs one cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      remain <= 17'h00000;
    end else if (start) begin
      remain <= 17'({7'h00, count} << scale) | 17'h00001; // RULE4
    end else if (remain != 17'h00000) begin
      remain <= remain - 17'h00001;
    end
  end

  assign busy = (remain != 17'h00000);

  a_wait_loads: assert property ( // RULE4
    @(posedge sys_clk) disable iff (!nrst)
    start |=> busy)
    else $error("wait timer did not start");

endmodule : rsc_wait_timer

// >>> pkg/rsc_pkg.sv
// Package: register map, field layout, reset values and types for the ramp tail
package rsc_pkg;

  // Register indices as printed; byte address is not used on this plain port
  localparam logic [7:0] RSC_ADDR_SUCC = 8'h69;
  localparam logic [7:0] RSC_ADDR_CAL  = 8'h6A;
  localparam logic [7:0] RSC_ADDR_LOCK = 8'h6E;
  localparam logic [7:0] RSC_ADDR_CAP  = 8'h6F;
  localparam logic [7:0] RSC_ADDR_AMP  = 8'h70;
  // Own registers: both segment lengths, trigger A select, control and status
  localparam logic [7:0] RSC_ADDR_LEN0 = 8'h64;
  localparam logic [7:0] RSC_ADDR_LEN1 = 8'h68;
  localparam logic [7:0] RSC_ADDR_TRGA = 8'h61;
  localparam logic [7:0] RSC_ADDR_CTRL = 8'h71;
  localparam logic [7:0] RSC_ADDR_STAT = 8'h72;

  // Field positions
  localparam int RSC_SUCC_BIT    = 4;
  localparam int RSC_SRC_LSB     = 0;
  localparam int RSC_DLY_LSB     = 6;
  localparam int RSC_RECAL_BIT   = 4;
  localparam int RSC_SCALE_LSB   = 0;
  localparam int RSC_LOCK_LSB    = 9;
  localparam int RSC_CORE_LSB    = 5;
  localparam int RSC_TRGA_LSB    = 3;

  // Reset values
  localparam logic [2:0] RSC_SCALE_RST = 3'h7;
  localparam logic [7:0] RSC_CAP_RST   = 8'hB7;
  localparam logic [8:0] RSC_AMP_RST   = 9'h0AA;
  localparam logic [15:0] RSC_LEN_RST  = 16'h0010;

  // Advance source codes
  localparam logic [1:0] RSC_SRC_LEN  = 2'h0;
  localparam logic [1:0] RSC_SRC_TRGA = 2'h1;
  localparam logic [1:0] RSC_SRC_TRGB = 2'h2;

  // Trigger A select codes
  localparam logic [3:0] RSC_TA_OFF   = 4'h0;
  localparam logic [3:0] RSC_TA_CLK_R = 4'h1;
  localparam logic [3:0] RSC_TA_DIR_R = 4'h2;
  localparam logic [3:0] RSC_TA_ALW   = 4'h4;
  localparam logic [3:0] RSC_TA_CLK_F = 4'h9;
  localparam logic [3:0] RSC_TA_DIR_F = 4'hA;

  // Calibration result carried from the synthesizer core
  typedef struct packed {
    logic [1:0] lock;
    logic [2:0] core;
    logic [7:0] cap;
    logic [8:0] amp;
  } rsc_cal_s;

endpackage : rsc_pkg

// >>> verification/rsc_ramp_tail_tb_top.sv
// Testbench: register access, readback and sequencer checks for the ramp tail
`timescale 1ns/1ps
module rsc_ramp_tail_tb_top
  import rsc_pkg::*;
;

  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [15:0] rdata;
  logic        ramp_clock_pin = 1'b0;
  logic        direction_pin = 1'b0;
  logic        trigger_b = 1'b0;
  logic        ramp_run = 1'b0;
  logic        cal_done = 1'b0;
  logic        cal_valid = 1'b0;
  rsc_cal_s    cal_result = '0;
  logic        active_segment;
  logic        cal_start;
  logic        ramp_hold;
  int          fail_count = 0;
  int          n_tests = 0;

  rsc_ramp_tail u_rsc_ramp_tail (
    .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ramp_clock_pin(ramp_clock_pin), .direction_pin(direction_pin),
    .trigger_b(trigger_b), .ramp_run(ramp_run), .cal_done(cal_done),
    .cal_valid(cal_valid), .cal_result(cal_result),
    .active_segment(active_segment), .cal_start(cal_start),
    .ramp_hold(ramp_hold));

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd

  function automatic logic pick(input int sel);
    case (sel)
      0:       return active_segment;
      1:       return cal_start;
      default: return ramp_hold;
    endcase
  endfunction : pick

  // Bounded wait for a sequencer output to reach a level
  task automatic wt(input int sel, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && pick(sel) !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({15'h0, pick(sel)}, {15'h0, v});
  endtask : wt

  // Level must still hold after n cycles
  task automatic st(input int sel, input logic v, input int n);
    repeat (n) @(posedge sys_clk);
    #1 chk({15'h0, pick(sel)}, {15'h0, v});
  endtask : st

  task automatic pulse_b();
    @(posedge sys_clk);
    trigger_b <= 1'b1;
    @(posedge sys_clk);
    trigger_b <= 1'b0;
  endtask : pulse_b

  task automatic pulse_done();
    @(posedge sys_clk);
    cal_done <= 1'b1;
    @(posedge sys_clk);
    cal_done <= 1'b0;
  endtask : pulse_done

  task automatic cal_set(input rsc_cal_s r, input logic [15:0] e_lock,
                         input logic [15:0] e_cap, input logic [15:0] e_amp);
    @(posedge sys_clk);
    cal_valid  <= 1'b1;
    cal_result <= r;
    @(posedge sys_clk);
    cal_valid <= 1'b0;
    rd(RSC_ADDR_LOCK, e_lock);
    rd(RSC_ADDR_CAP, e_cap);
    rd(RSC_ADDR_AMP, e_amp);
  endtask : cal_set

  // Pin edge against trigger A code; e1 after rise, e2 after fall
  task automatic tcase(input logic [3:0] c, input logic dir,
                       input logic e1, input logic e2);
    wr(RSC_ADDR_TRGA, {9'h000, c, 3'h0});
    wt(0, 1'b1, 80);
    @(posedge sys_clk);
    if (dir) direction_pin <= 1'b1;
    else ramp_clock_pin <= 1'b1;
    st(0, e1, 8);
    @(posedge sys_clk);
    if (dir) direction_pin <= 1'b0;
    else ramp_clock_pin <= 1'b0;
    st(0, e2, 8);
  endtask : tcase

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(RSC_ADDR_SUCC, 16'h0000);
    rd(RSC_ADDR_CAL, 16'h0007);
    rd(RSC_ADDR_LOCK, 16'h0000);
    rd(RSC_ADDR_CAP, 16'h00B7);
    rd(RSC_ADDR_AMP, 16'h00AA);
    rd(8'h00, 16'h0000);
    st(0, 1'b0, 0);
    $display("test reset values done");
    cal_set({2'h2, 3'h7, 8'hC3, 9'h1F3}, 16'h04E0, 16'h00C3, 16'h01F3);
    cal_set({2'h3, 3'h1, 8'h00, 9'h000}, 16'h0620, 16'h0000, 16'h0000);
    cal_set({2'h1, 3'h0, 8'hFF, 9'h1FF}, 16'h0200, 16'h00FF, 16'h01FF);
    wr(RSC_ADDR_CAP, 16'h0011);
    rd(RSC_ADDR_CAP, 16'h00FF);
    $display("test readback done");
    // Long second segment so only the trigger can end it
    wr(RSC_ADDR_LEN0, 16'h0028);
    wr(RSC_ADDR_LEN1, 16'hFFFF);
    wr(RSC_ADDR_SUCC, 16'h0001);
    ramp_run <= 1'b1;
    tcase(RSC_TA_CLK_R, 1'b0, 1'b0, 1'b0);
    tcase(RSC_TA_DIR_R, 1'b1, 1'b0, 1'b0);
    tcase(RSC_TA_CLK_F, 1'b0, 1'b1, 1'b0);
    tcase(RSC_TA_DIR_F, 1'b1, 1'b1, 1'b0);
    tcase(RSC_TA_ALW, 1'b0, 1'b0, 1'b0);
    tcase(RSC_TA_OFF, 1'b0, 1'b1, 1'b1);
    $display("test trigger a done");
    wr(RSC_ADDR_SUCC, 16'h0002);
    wt(0, 1'b1, 80);
    st(0, 1'b1, 10);
    pulse_b();
    wt(0, 1'b0, 3);
    wr(RSC_ADDR_LEN1, 16'h0004);
    wr(RSC_ADDR_SUCC, 16'h0003);
    wt(0, 1'b1, 80);
    pulse_b();
    st(0, 1'b1, 30);
    wr(RSC_ADDR_SUCC, 16'h0000);
    wt(0, 1'b0, 12);
    wr(RSC_ADDR_SUCC, 16'h0010);
    rd(RSC_ADDR_SUCC, 16'h0010);
    wt(0, 1'b1, 80);
    st(0, 1'b1, 40);
    $display("test successor done");
    // Freeze the ramp so the one-cycle cal_start cannot slip past unseen
    @(posedge sys_clk);
    ramp_run <= 1'b0;
    // Wait count 10 scaled by 8 outlasts an early calibration finish
    wr(RSC_ADDR_SUCC, 16'h0280);
    wr(RSC_ADDR_CAL, 16'h0013);
    rd(RSC_ADDR_CAL, 16'h0013);
    @(posedge sys_clk);
    ramp_run <= 1'b1;
    wt(1, 1'b1, 30);
    st(2, 1'b1, 0);
    pulse_done();
    st(2, 1'b1, 60);
    wt(2, 1'b0, 60);
    // Short count: a late calibration sets the wait
    wr(RSC_ADDR_CAL, 16'h0010);
    wr(RSC_ADDR_SUCC, 16'h0040);
    wt(1, 1'b1, 100);
    st(2, 1'b1, 25);
    pulse_done();
    wt(2, 1'b0, 10);
    $display("test recalibration done");
    stop_test();
  end

  // Watchdog well beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end

endmodule : rsc_ramp_tail_tb_top
